// ==== hw/fps_front_panel.sv ====
// Operator front-panel sequencer: run/stop, single step, examine,
// examine/store following, store, panel port and bus-drive gating.
// Assumes processor strobes are synchronous to REF_CLK; switches are not.
//
// Function
// - Following functions feed idle opcode to advance
// - Ready is OR of four panel states
// - Processor runs only while panel ready high
// - Allow one instruction, then drop ready
// - Step pulse trailing edge sets step flop
// - Step flop clears on next sync
// - Following flop set by pulse leading edge
// - Following flop injects idle, ready; sync clears
// - Examine pulse starts counter; first injects jump
// - Then low, high address; zero drops ready
// - Store pulse drives memory write line
// - Longer pulse drives data switches onto bus
// - Store triggers from switch or following pulse
// - Bus driver disabled while panel injects or drives data, not on port FF reads
// - Injected bytes gated by read strobe
// - Port FF read drives high address switches
// - Port FF output latches lamps on write
// - Status disable tracks port FF read gate
// - External clear on aux switch or reset
// - Run after examine resumes at address
// - Run sets on phase-two falling edge
// - Stop clears at sync with fetch status
// - Jump opcode then two address bytes
`timescale 1ns/1ps
module fps_front_panel
  import fps_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int unsigned DATA_PULSE_CYCLES = DATA_PULSE_CYC
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // Operator switches (asynchronous levels)
  input wire logic SW_RUN_SEL,
  input wire logic SW_STEP_REQ,
  input wire logic SW_EXAMINE_REQ,
  input wire logic SW_EXAMINE_NEXT_REQ,
  input wire logic SW_STORE_REQ,
  input wire logic SW_STORE_NEXT_REQ,
  input wire logic SW_RESET_REQ,
  input wire logic SW_AUX_CLEAR_REQ,
  input wire logic [15:0] SW_ADDR,
  // Processor status and strobes (same clock domain)
  input wire logic PHI2,
  input wire logic SYNC,
  input wire logic STAT_FETCH,
  input wire logic STAT_OUT,
  input wire logic PDBIN,
  input wire logic WR_STROBE_N,
  input wire logic [7:0] ADDR_LOW,
  // Processor data bus, open-collector style
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic [7:0] DATA_OE_N,
  // Backplane control outputs
  output logic X_READY,
  output logic RUN_LAMP,
  output logic MEM_WRITE,
  output logic CPU_DRIVER_DISABLE,
  output logic SWITCH_STATUS_DISABLE,
  output logic RESET_OUT_N,
  output logic EXT_CLEAR,
  // Programmed output lamps
  output logic [7:0] LAMPS
);
  localparam int unsigned DW = $clog2(DATA_PULSE_CYCLES + 1);
  localparam int unsigned SW_W = $clog2(STEP_PULSE_CYC + 1);

  typedef enum logic [1:0] {EX_IDLE, EX_JUMP, EX_LOW, EX_HIGH} fps_exam_e;

  // Debounced switches
  logic [SW_COUNT-1:0] sw_raw;
  logic [SW_COUNT-1:0] sw_cln;
  logic [SW_COUNT-1:0] sw_prev_r;
  logic [SW_COUNT-1:0] sw_rise;
  logic rst_sw;
  logic aux_sw;

  assign sw_raw = {SW_STORE_NEXT_REQ, SW_STORE_REQ, SW_EXAMINE_NEXT_REQ,
                   SW_EXAMINE_REQ, SW_STEP_REQ, SW_RUN_SEL};
  assign sw_rise = sw_cln & ~sw_prev_r;

  // One filter per switch; clean levels only feed logic after two flops
  genvar gi;
  generate
    for (gi = 0; gi < SW_COUNT; gi++)
    begin : g_sw
      fps_debounce #(.STABLE_CYC(DEBOUNCE_CYCLES)) u_db (
        .clk(REF_CLK),
        .rst_n(RESETN),
        .raw(sw_raw[gi]),
        .clean(sw_cln[gi])
      );
    end
  endgenerate

  fps_debounce #(.STABLE_CYC(DEBOUNCE_CYCLES)) u_db_rst (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .raw(SW_RESET_REQ),
    .clean(rst_sw)
  );

  fps_debounce #(.STABLE_CYC(DEBOUNCE_CYCLES)) u_db_aux (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .raw(SW_AUX_CLEAR_REQ),
    .clean(aux_sw)
  );

  // Address/data switches are loose levels; two flops before any use
  // A switch flipped during a read may give a byte of mixed old/new bits
  logic [15:0] addr_s1_r;
  logic [15:0] addr_s2_r;

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      addr_s1_r <= 16'h0000;
      addr_s2_r <= 16'h0000;
    end
    else
    begin
      addr_s1_r <= SW_ADDR;
      addr_s2_r <= addr_s1_r;
    end
  end

  // State registers
  logic run_r;
  logic step_r;
  logic follow_r;
  fps_exam_e exam_r;
  fps_exam_e exam_nxt;
  logic [SW_W-1:0] step_os_r;
  logic [SW_W-1:0] follow_os_r;
  logic [SW_W-1:0] wr_os_r;
  logic [DW-1:0] data_os_r;
  logic follow_store_r;
  logic phi2_prev_r;
  logic pdbin_prev_r;
  logic [7:0] data_out_r;
  logic [7:0] data_oe_n_r;
  logic ready_r;
  logic drv_dis_r;
  logic ssd_r;
  logic mwr_r;
  logic [7:0] lamps_r;
  logic rst_out_n_r;
  logic ext_clr_r;

  // Decoding of one-shot edges and bus windows
  wire step_os_on = step_os_r != '0;
  wire step_os_end = step_os_r == SW_W'(1);
  wire follow_os_end = follow_os_r == SW_W'(1);
  wire follow_trig = sw_rise[SW_EXNX] | sw_rise[SW_STNX];
  wire store_trig = sw_rise[SW_STOR]
                    | (follow_os_end & follow_store_r);
  wire data_on = data_os_r != '0;
  wire exam_on = exam_r != EX_IDLE;
  wire phi2_fall = phi2_prev_r & ~PHI2;
  wire fetch_sync = SYNC & STAT_FETCH;
  wire read_end = pdbin_prev_r & ~PDBIN;
  wire port_hit = ADDR_LOW == PANEL_PORT;
  wire port_rd = port_hit & PDBIN & ~STAT_OUT;
  wire lamp_en = port_hit & STAT_OUT;
  wire inject_idle = follow_r & PDBIN;
  wire inject_jump = (exam_r == EX_JUMP) & PDBIN;
  wire inject_low = (exam_r == EX_LOW) & PDBIN;
  wire inject_high = (exam_r == EX_HIGH) & PDBIN;
  wire data_drv = data_on & PDBIN;
  wire any_drv = inject_idle | inject_jump | inject_low | inject_high
                 | data_drv | port_rd;

  // Byte to place on the bus, pulled low where a bit is zero
  logic [7:0] bus_byte;
  assign bus_byte = inject_jump ? OP_JUMP :
                    inject_low ? addr_s2_r[7:0] :
                    (inject_high | port_rd) ? addr_s2_r[15:8] :
                    data_drv ? addr_s2_r[7:0] :
                    OP_IDLE;

  // Examine counter starts on the switch, then advances at the end of each read window
  always_comb
  begin
    exam_nxt = exam_r;
    case (exam_r)
      EX_IDLE: if (sw_rise[SW_EXAM]) exam_nxt = EX_JUMP;
      EX_JUMP: if (read_end) exam_nxt = EX_LOW;
      EX_LOW: if (read_end) exam_nxt = EX_HIGH;
      EX_HIGH: if (read_end) exam_nxt = EX_IDLE;
      default: exam_nxt = EX_IDLE;
    endcase
  end

  // Run/stop flop, edge history and switch history
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      run_r <= 1'b0;
      phi2_prev_r <= 1'b0;
      pdbin_prev_r <= 1'b0;
      sw_prev_r <= '0;
    end
    else
    begin
      phi2_prev_r <= PHI2;
      pdbin_prev_r <= PDBIN;
      sw_prev_r <= sw_cln;
      if (sw_cln[SW_RUN] && phi2_fall)
        run_r <= 1'b1;
      else if (!sw_cln[SW_RUN] && fetch_sync)
        run_r <= 1'b0;
    end
  end

  // Single step: pulse counter, then flop until next sync
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      step_os_r <= '0;
      step_r <= 1'b0;
    end
    else
    begin
      if (sw_rise[SW_STEP] && !step_os_on)
        step_os_r <= SW_W'(STEP_PULSE_CYC);
      else if (step_os_on)
        step_os_r <= step_os_r - 1'b1;
      // Trailing edge wins over a coincident sync so the step is not lost
      if (step_os_end)
        step_r <= 1'b1;
      else if (SYNC && step_r)
        step_r <= 1'b0;
    end
  end

  // Following: flop set at pulse start, store chained at pulse end
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      follow_os_r <= '0;
      follow_r <= 1'b0;
      follow_store_r <= 1'b0;
    end
    else
    begin
      if (follow_trig && follow_os_r == '0)
      begin
        follow_os_r <= SW_W'(STEP_PULSE_CYC);
        follow_store_r <= sw_rise[SW_STNX];
      end
      else if (follow_os_r != '0)
        follow_os_r <= follow_os_r - 1'b1;
      if (follow_trig)
        follow_r <= 1'b1;
      else if (SYNC && follow_r)
        follow_r <= 1'b0;
    end
  end

  // Examine sequence and store one-shots
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      exam_r <= EX_IDLE;
      wr_os_r <= '0;
      data_os_r <= '0;
    end
    else
    begin
      exam_r <= exam_nxt;
      if (store_trig)
      begin
        wr_os_r <= SW_W'(WR_PULSE_CYC);
        data_os_r <= DW'(DATA_PULSE_CYCLES);
      end
      else
      begin
        if (wr_os_r != '0)
          wr_os_r <= wr_os_r - 1'b1;
        if (data_on)
          data_os_r <= data_os_r - 1'b1;
      end
    end
  end

  // Registered backplane outputs
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ready_r <= 1'b0;
      data_out_r <= 8'hFF;
      data_oe_n_r <= 8'hFF;
      drv_dis_r <= 1'b0;
      ssd_r <= 1'b0;
      mwr_r <= 1'b0;
      rst_out_n_r <= 1'b1;
      ext_clr_r <= 1'b0;
    end
    else
    begin
      ready_r <= run_r | step_r | exam_on | follow_r;
      data_out_r <= 8'h00;
      data_oe_n_r <= any_drv ? bus_byte : 8'hFF;
      drv_dis_r <= data_on | follow_r | exam_on;
      ssd_r <= port_rd;
      mwr_r <= wr_os_r != '0;
      rst_out_n_r <= ~rst_sw;
      ext_clr_r <= aux_sw | rst_sw;
    end
  end

  // Output lamp latch captures the bus on the write strobe
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      lamps_r <= LAMP_RESET;
    else if (lamp_en && !WR_STROBE_N)
      lamps_r <= DATA_IN;
  end

  assign X_READY = ready_r;
  assign RUN_LAMP = run_r;
  assign MEM_WRITE = mwr_r;
  assign CPU_DRIVER_DISABLE = drv_dis_r; // Active high, the inverse of NOR
  assign SWITCH_STATUS_DISABLE = ssd_r;
  assign RESET_OUT_N = rst_out_n_r;
  assign EXT_CLEAR = ext_clr_r;
  assign DATA_OUT = data_out_r;
  assign DATA_OE_N = data_oe_n_r;
  assign LAMPS = lamps_r;
endmodule

// ==== hw/fps_pkg.sv ====
// Package for the operator front-panel sequencer: opcodes, port address,
// one-shot lengths and the synchroniser/debounce figures.
// Assumes a 25 MHz reference clock.
package fps_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CLK_NS = 40;
  // Opcodes injected onto the processor data bus
  localparam logic [7:0] OP_IDLE = 8'h00;
  localparam logic [7:0] OP_JUMP = 8'hC3;
  // Panel input/output port address
  localparam logic [7:0] PANEL_PORT = 8'hFF;
  // Pulse lengths in ns, and their cycle counts (least times round up)
  localparam int unsigned STEP_PULSE_NS = 400;
  localparam int unsigned WR_PULSE_NS = 400;
  localparam int unsigned DATA_PULSE_NS = 2000;
  localparam int unsigned DEBOUNCE_US = 200;
  localparam int unsigned STEP_PULSE_CYC =
    (STEP_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WR_PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DATA_PULSE_CYC =
    (DATA_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1000000);
  localparam int unsigned SW_COUNT = 6;
  // Switch indices in the debounced vector
  localparam int unsigned SW_RUN = 0;
  localparam int unsigned SW_STEP = 1;
  localparam int unsigned SW_EXAM = 2;
  localparam int unsigned SW_EXNX = 3;
  localparam int unsigned SW_STOR = 4;
  localparam int unsigned SW_STNX = 5;
  // Reset values
  localparam logic [7:0] LAMP_RESET = 8'h00;
endpackage

// ==== hw/fps_debounce.sv ====
// Two-flop synchroniser followed by a stability counter for one switch.
// Assumes the switch is an asynchronous, possibly bouncing level.
`timescale 1ns/1ps
module fps_debounce #(
  parameter int unsigned STABLE_CYC = 5000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw switch and clean level
  input wire logic raw,
  output logic clean
);
  localparam int unsigned CW = $clog2(STABLE_CYC + 1);
  logic s1_r;
  logic s2_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic clean_r;
  wire differ = s2_r != clean_r;
  wire settled = cnt_r == CW'(STABLE_CYC - 1);

  // Count while the sampled level differs; any agreement restarts it
  assign cnt_nxt = differ ? (settled ? '0 : cnt_r + 1'b1) : '0;
  assign clean = clean_r;

  // Synchroniser and filter; only s2_r is looked at downstream of s1_r
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      cnt_r <= '0;
      clean_r <= 1'b0;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
      cnt_r <= cnt_nxt;
      if (differ && settled)
        clean_r <= s2_r;
    end
  end
endmodule

// ==== verif/fps_cpu_model.sv ====
// Processor model: fetch cycles of sync, read and idle.
// Assumes the panel shares its clock; it waits in the read for ready.
`timescale 1ns/1ps
module fps_cpu_model (
  // Clock, reset and panel lines
  input wire logic clk,
  input wire logic rst_n,
  input wire logic x_ready,
  input wire logic reset_out_n,
  // Status and strobes
  output logic phi2,
  output logic sync,
  output logic stat_fetch,
  output logic pdbin,
  output logic por_clear
);
  logic [1:0] ph_r;
  // Hold the read while ready is low, as a halted processor does
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_r <= 2'h0;
      phi2 <= 1'b0;
    end
    else
    begin
      phi2 <= ~phi2;
      if (ph_r != 2'h1 || x_ready)
        ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
    end
  end
  // Every cycle is a fetch, so fetch status rides on sync
  assign sync = ph_r == 2'h0;
  assign stat_fetch = sync;
  assign pdbin = ph_r == 2'h1;
  assign por_clear = !reset_out_n;
endmodule

// ==== verif/fps_front_panel_sva.sv ====
// Port checker for the front-panel sequencer.
// Assumes it is bound into fps_front_panel.
`timescale 1ns/1ps
module fps_front_panel_sva
  import fps_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // Inputs
  input wire logic [15:0] SW_ADDR,
  input wire logic STAT_OUT,
  input wire logic PDBIN,
  input wire logic WR_STROBE_N,
  input wire logic [7:0] ADDR_LOW,
  input wire logic [7:0] DATA_IN,
  // Outputs
  input wire logic [7:0] DATA_OE_N,
  input wire logic X_READY,
  input wire logic RUN_LAMP,
  input wire logic MEM_WRITE,
  input wire logic CPU_DRIVER_DISABLE,
  input wire logic SWITCH_STATUS_DISABLE,
  input wire logic RESET_OUT_N,
  input wire logic EXT_CLEAR,
  input wire logic [7:0] LAMPS
);
  logic rd_r;
  logic [7:0] wr_len_r;
  logic drv;
  logic wr;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // Port cycle decodes
  assign wr = ADDR_LOW == PANEL_PORT && STAT_OUT && !WR_STROBE_N;
  assign drv = DATA_OE_N != 8'hFF;
  // Outputs are registered, so compare against last edge's read
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN)
      rd_r <= 1'b0;
    else
      rd_r <= ADDR_LOW == PANEL_PORT && PDBIN && !STAT_OUT;
  // Cycles the write line has stood high so far
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN)
      wr_len_r <= 8'h00;
    else if (MEM_WRITE)
      wr_len_r <= wr_len_r + 8'h01;
    else
      wr_len_r <= 8'h00;
  a_ext_on_reset: assert property (!RESET_OUT_N |-> EXT_CLEAR)
    else $error("no clear in reset");
  a_bus_driver_off: assert property (drv |-> CPU_DRIVER_DISABLE ||
    SWITCH_STATUS_DISABLE) else $error("driver not disabled");
  a_drive_in_read: assert property (drv |-> $past(PDBIN))
    else $error("drive outside read");
  a_write_pulse: assert property ($fell(MEM_WRITE) |->
    wr_len_r == 8'(WR_PULSE_CYC)) else $error("write length");
  a_write_bound: assert property (wr_len_r <= 8'(WR_PULSE_CYC))
    else $error("write too long");
  a_status_off: assert property (SWITCH_STATUS_DISABLE == rd_r)
    else $error("status disable");
  a_port_data: assert property (rd_r |-> DATA_OE_N == SW_ADDR[15:8])
    else $error("port data");
  a_lamp_load: assert property (wr |=> LAMPS == $past(DATA_IN))
    else $error("lamp load");
  a_lamp_hold: assert property (!wr |=> $stable(LAMPS))
    else $error("lamp changed");
  a_run_ready: assert property (RUN_LAMP |=> X_READY)
    else $error("run without ready");
  c_store: cover property ($rose(MEM_WRITE));
  c_port: cover property (rd_r);
  c_lamp: cover property (wr);
endmodule
bind fps_front_panel fps_front_panel_sva u_sva (
  .REF_CLK(REF_CLK), .RESETN(RESETN), .SW_ADDR(SW_ADDR),
  .STAT_OUT(STAT_OUT), .PDBIN(PDBIN), .WR_STROBE_N(WR_STROBE_N),
  .ADDR_LOW(ADDR_LOW), .DATA_IN(DATA_IN), .DATA_OE_N(DATA_OE_N),
  .X_READY(X_READY), .RUN_LAMP(RUN_LAMP), .MEM_WRITE(MEM_WRITE),
  .CPU_DRIVER_DISABLE(CPU_DRIVER_DISABLE),
  .SWITCH_STATUS_DISABLE(SWITCH_STATUS_DISABLE),
  .RESET_OUT_N(RESET_OUT_N), .EXT_CLEAR(EXT_CLEAR), .LAMPS(LAMPS)
);

// ==== verif/fps_front_panel_bench.sv ====
// Bench for the front-panel sequencer against a processor model.
// Assumes a debounce count of 4 so switch presses stay short.
`timescale 1ns/1ps
module fps_front_panel_bench;
  import fps_pkg::*;
  logic REF_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [7:0] sw = 8'h00;
  logic [15:0] SW_ADDR = 16'h1234;
  logic STAT_OUT = 1'b0;
  logic WR_STROBE_N = 1'b1;
  logic [7:0] ADDR_LOW = 8'h00;
  logic [7:0] cpu_byte = 8'hFF;
  logic PHI2, SYNC, STAT_FETCH, PDBIN, por_clear, X_READY, RUN_LAMP;
  logic MEM_WRITE, CPU_DRIVER_DISABLE, SWITCH_STATUS_DISABLE;
  logic RESET_OUT_N, EXT_CLEAR;
  logic [7:0] DATA_IN, DATA_OUT, DATA_OE_N, LAMPS;
  logic [3:0] obs;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Wired-AND bus: any puller wins
  assign DATA_IN = DATA_OE_N & cpu_byte;
  assign obs = {RESET_OUT_N, EXT_CLEAR, MEM_WRITE, X_READY};
  always #20 REF_CLK = ~REF_CLK;
  fps_front_panel #(.DEBOUNCE_CYCLES(4)) DUT (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .SW_RUN_SEL(sw[SW_RUN]),
    .SW_STEP_REQ(sw[SW_STEP]), .SW_EXAMINE_REQ(sw[SW_EXAM]),
    .SW_EXAMINE_NEXT_REQ(sw[SW_EXNX]), .SW_STORE_REQ(sw[SW_STOR]),
    .SW_STORE_NEXT_REQ(sw[SW_STNX]), .SW_RESET_REQ(sw[6]),
    .SW_AUX_CLEAR_REQ(sw[7]), .SW_ADDR(SW_ADDR), .PHI2(PHI2),
    .SYNC(SYNC), .STAT_FETCH(STAT_FETCH), .STAT_OUT(STAT_OUT),
    .PDBIN(PDBIN), .WR_STROBE_N(WR_STROBE_N), .ADDR_LOW(ADDR_LOW),
    .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
    .X_READY(X_READY), .RUN_LAMP(RUN_LAMP), .MEM_WRITE(MEM_WRITE),
    .CPU_DRIVER_DISABLE(CPU_DRIVER_DISABLE),
    .SWITCH_STATUS_DISABLE(SWITCH_STATUS_DISABLE),
    .RESET_OUT_N(RESET_OUT_N), .EXT_CLEAR(EXT_CLEAR), .LAMPS(LAMPS)
  );
  fps_cpu_model cpu (.clk(REF_CLK), .rst_n(RESETN), .x_ready(X_READY),
    .reset_out_n(RESET_OUT_N), .phi2(PHI2), .sync(SYNC),
    .stat_fetch(STAT_FETCH), .pdbin(PDBIN), .por_clear(por_clear));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Run needs under 2000 cycles
  always @(posedge REF_CLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // Bounded wait on one observed line, then compare
  task automatic wt(input int i, input logic v);
    int k;
    k = 0;
    while (obs[i] !== v && k < 90)
    begin
      tick();
      k++;
    end
    chk({7'h00, obs[i]}, {7'h00, v});
  endtask
  // Next panel drive on the bus; bus level equals the enables
  task automatic rd(input logic [7:0] e);
    int k;
    k = 0;
    while (DATA_OE_N === 8'hFF && k < 90)
    begin
      tick();
      k++;
    end
    chk(DATA_OE_N, e);
    while (DATA_OE_N !== 8'hFF && k < 180)
    begin
      tick();
      k++;
    end
  endtask
  task automatic rel(input int i);
    sw[i] = 1'b0;
    tick(12);
  endtask
  task automatic t_run;
    sw[SW_RUN] = 1'b1;
    wt(0, 1'b1);
    chk({7'h00, RUN_LAMP}, 8'h01);
    ADDR_LOW = PANEL_PORT;
    rd(SW_ADDR[15:8]);
    STAT_OUT = 1'b1;
    WR_STROBE_N = 1'b0;
    cpu_byte = 8'hA5;
    tick(2);
    WR_STROBE_N = 1'b1;
    STAT_OUT = 1'b0;
    ADDR_LOW = 8'h00;
    cpu_byte = 8'hFF;
    chk(LAMPS, 8'hA5);
    rel(SW_RUN);
    wt(0, 1'b0);
    $display("run done");
  endtask
  task automatic t_step;
    sw[SW_STEP] = 1'b1;
    wt(0, 1'b1);
    wt(0, 1'b0);
    rel(SW_STEP);
    $display("step done");
  endtask
  task automatic t_exam;
    sw[SW_EXAM] = 1'b1;
    rd(OP_JUMP);
    rd(SW_ADDR[7:0]);
    rd(SW_ADDR[15:8]);
    wt(0, 1'b0);
    rel(SW_EXAM);
    $display("examine done");
  endtask
  task automatic t_next;
    sw[SW_EXNX] = 1'b1;
    rd(OP_IDLE);
    wt(0, 1'b0);
    rel(SW_EXNX);
    $display("next done");
  endtask
  task automatic t_store(input int i);
    int k;
    k = 0;
    sw[i] = 1'b1;
    if (i == SW_STNX)
      rd(OP_IDLE);
    wt(1, 1'b1);
    while (MEM_WRITE === 1'b1 && k < 40)
    begin
      tick();
      k++;
    end
    chk(k[7:0], 8'(WR_PULSE_CYC));
    rd(SW_ADDR[7:0]);
    rel(i);
    $display("store done");
  endtask
  task automatic t_clr;
    sw[7] = 1'b1;
    wt(2, 1'b1);
    rel(7);
    sw[6] = 1'b1;
    wt(3, 1'b0);
    chk({7'h00, EXT_CLEAR}, 8'h01);
    chk({7'h00, por_clear}, 8'h01);
    rel(6);
    $display("clear done");
  endtask
  initial
  begin
    tick(2);
    RESETN = 1'b1;
    tick(2);
    chk(LAMPS, LAMP_RESET);
    chk(DATA_OE_N, 8'hFF);
    chk(DATA_OUT, 8'h00);
    t_run();
    t_step();
    t_exam();
    t_next();
    t_store(SW_STOR);
    t_store(SW_STNX);
    t_clr();
    wrap_up();
  end
endmodule
